// *** core/idle_wake_pkg.sv ***
package idle_wake_pkg;

  // Clock period of the control logic
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Delay figures in nanoseconds, plain defaults
  localparam int unsigned CPU_START_NS = 2000;
  localparam int unsigned STABILIZE_NS = 10000;
  localparam int unsigned OSC_STARTUP_NS = 51200;
  localparam int unsigned PLL_LOCK_NS = 2000000;

  // Least times round up to whole cycles
  localparam int unsigned CPU_START_CYC = (CPU_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STABILIZE_CYC = (STABILIZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_STARTUP_CYC = (OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width and interrupt source count
  localparam int unsigned DELAY_WIDTH = 16;
  localparam int unsigned IRQ_COUNT = 8;

  // Internal frequency select code meaning 1 MHz
  localparam logic [2:0] FREQ_SEL_RESET = 3'h3;
  localparam logic [2:0] FREQ_SEL_OFF = 3'h0;

  // Clock select field positions
  localparam int unsigned SEL_HI_BIT = 1;
  localparam int unsigned SEL_LO_BIT = 0;

  // Status flag reset values
  localparam logic PRI_FLAG_RESET = 1'b1;
  localparam logic SEC_FLAG_RESET = 1'b0;

  // Power mode of the core
  typedef enum logic [2:0] {M_RUN, M_SLEEP, M_SECONDARY_IDLE_MODE, M_INT_IDLE, M_PRIMARY_IDLE_MODE, M_WAKE} mode_t;

  // Clock source feeding core and peripherals
  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} src_t;

  // Why the wake began
  typedef enum logic [1:0] {WK_IRQ, WK_WDT, WK_RST} cause_t;

  // Kind of primary oscillator configured
  typedef enum logic [1:0] {PK_CRYSTAL, PK_CRYSTAL_PLL, PK_EXT_RC, PK_INTERNAL} prim_t;

endpackage

// *** core/delay_timer.sv ***
`timescale 1ns/10ps
module delay_timer
  import idle_wake_pkg::*;
#(
  parameter int unsigned W = DELAY_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Start request and length in cycles
  input wire logic start,
  input wire logic [W-1:0] load,
  // Progress
  output logic busy,
  output logic done
);

  // Whole timer state
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_t;

  tmr_t r_reg;
  tmr_t r_next;

  // Count down; a zero length behaves as one cycle
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.cnt = (load == '0) ? W'(1) : load;
      r_next.busy = 1'b1;
    end else if (r_reg.busy) begin
      if (r_reg.cnt == W'(1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy = r_reg.busy;
  assign done = r_reg.done;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_done_single_pulse: assert property (done |=> !done)
    else $error("delay done lasted more than one cycle");
  a_start_busy: assert property (start |=> busy && !done)
    else $error("delay not busy after start");

endmodule

// *** core/idle_wake_ctrl.sv ***
`timescale 1ns/10ps
module idle_wake_ctrl
  import idle_wake_pkg::*;
#(
  parameter int unsigned W = DELAY_WIDTH,
  parameter int unsigned IRQ_N = IRQ_COUNT,
  parameter int unsigned CPU_START = CPU_START_CYC,
  parameter int unsigned STABILIZE = STABILIZE_CYC,
  parameter int unsigned OSC_STARTUP = OSC_STARTUP_CYC,
  parameter int unsigned PLL_LOCK = PLL_LOCK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Instruction events from the core
  input wire logic sleep_exec,
  input wire logic watchdog_clear_exec,
  // Oscillator control bits
  input wire logic idle_select,
  input wire logic [1:0] system_clock_select,
  input wire logic secondary_osc_force_on,
  input wire logic timer_a_secondary_osc_enable,
  input wire logic timer_b_secondary_osc_enable,
  input wire logic timer_c_secondary_osc_enable,
  input wire logic low_freq_source_select,
  input wire logic medium_freq_select,
  // Internal frequency select write port
  input wire logic freq_write,
  input wire logic [2:0] freq_wdata,
  // Configuration
  input wire prim_t primary_kind,
  input wire logic watchdog_enable,
  input wire logic failsafe_enable,
  // Wake sources; clock loss only clears the watchdog
  input wire logic [IRQ_N-1:0] irq_flag,
  input wire logic [IRQ_N-1:0] irq_enable,
  input wire logic global_interrupt_enable,
  input wire logic watchdog_timeout,
  input wire logic reset_wake,
  input wire logic clock_lost,
  // Clock gating and oscillator enables
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output src_t clock_source,
  output logic primary_osc_en,
  output logic secondary_osc_en,
  output logic high_freq_internal_en,
  output logic low_freq_internal_en,
  // Status flags
  output logic primary_clock_running_flag,
  output logic secondary_clock_running_flag,
  output logic high_internal_stable_flag,
  output logic medium_internal_stable_flag,
  output logic [2:0] internal_freq_select,
  // Core sequencing pulses
  output logic resume_exec,
  output logic vector_request,
  output logic restart_at_zero,
  output logic watchdog_clear,
  output logic watchdog_reset,
  output mode_t power_mode
);

  // Whole controller state
  typedef struct packed {
    mode_t st;
    src_t src;
    cause_t cause;
    logic pri_flag;
    logic sec_flag;
    logic stable;
    logic cpu_start_delay_ok;
    logic osc_ok;
    logic need_pll;
    logic vec_pend;
    logic resume;
    logic vector;
    logic restart;
    logic wdt_clr;
    logic wdt_rst;
    logic [2:0] ifs;
    logic [W-1:0] wcnt;
  } ctl_t;

  ctl_t r_reg;
  ctl_t r_next;

  // Timer handshakes
  logic cpu_start_delay_go, cpu_start_delay_done;
  logic stab_go, stab_busy, stab_done;
  logic ost_go, ost_done;
  logic pll_go, pll_done;

  // Derived conditions
  logic secondary_oscillator_any;
  logic hf_req;
  logic hf_on;
  logic irq_pend;
  logic wake;

  // True when the primary kind needs the start-up timer
  function automatic logic needs_ost(input prim_t k);
    return (k == PK_CRYSTAL) || (k == PK_CRYSTAL_PLL);
  endfunction

  // Any secondary oscillator enable keeps that oscillator alive
  assign secondary_oscillator_any = secondary_osc_force_on | timer_a_secondary_osc_enable |
                    timer_b_secondary_osc_enable | timer_c_secondary_osc_enable;
  // Internal output wanted only with a nonzero select or source bit
  assign hf_req = (r_reg.ifs != FREQ_SEL_OFF) | low_freq_source_select;
  // Selected oscillator stops in full sleep
  assign hf_on = hf_req && (r_reg.st != M_SLEEP);
  // Only enabled interrupts may wake the device; watchdog time-out and reset wake need no enable
  assign irq_pend = |(irq_flag & irq_enable);
  assign wake = irq_pend | watchdog_timeout | reset_wake;

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.resume = 1'b0;
    r_next.vector = 1'b0;
    r_next.restart = 1'b0;
    r_next.wdt_rst = 1'b0;
    cpu_start_delay_go = 1'b0;
    ost_go = 1'b0;
    pll_go = 1'b0;
    // Software updates the frequency select at any time
    if (freq_write) begin
      r_next.ifs = freq_wdata;
    end
    // Watchdog clear events
    r_next.wdt_clr = (sleep_exec && r_reg.st == M_RUN) | watchdog_clear_exec |
                     (clock_lost & failsafe_enable) |
                     (freq_write && r_reg.src == SRC_INT);
    // Stability tracking; a stable source stays stable across idle entry
    stab_go = hf_on && !r_reg.stable && !stab_busy;
    if (!hf_on) begin
      r_next.stable = 1'b0;
    end else if (stab_done) begin
      r_next.stable = 1'b1;
    end
    unique case (r_reg.st)
      M_RUN: begin
        // Vector goes out one cycle after the next instruction resumes
        r_next.vector = r_reg.vec_pend;
        r_next.vec_pend = 1'b0;
        if (watchdog_timeout) begin
          r_next.wdt_rst = 1'b1;
        end else if (sleep_exec) begin
          if (!idle_select) begin
            // Full sleep: all clock status cleared
            r_next.st = M_SLEEP;
            r_next.pri_flag = 1'b0;
            // Clear stability at entry, not one cycle later when the output drops
            r_next.stable = 1'b0;
            r_next.sec_flag = 1'b0;
          end else if (system_clock_select[SEL_HI_BIT]) begin
            // Lower select bit is a don't care here
            r_next.st = M_INT_IDLE;
            r_next.src = SRC_INT;
            r_next.pri_flag = 1'b0;
            r_next.sec_flag = 1'b0;
          end else if (system_clock_select[SEL_LO_BIT] && secondary_oscillator_any) begin
            r_next.st = M_SECONDARY_IDLE_MODE;
            r_next.src = SRC_SEC;
            r_next.pri_flag = 1'b0;
            r_next.sec_flag = 1'b1;
          end else if (system_clock_select[SEL_LO_BIT]) begin
            // No secondary enable: idle on whatever clock ran before
            r_next.st = (r_reg.src == SRC_INT) ? M_INT_IDLE : M_PRIMARY_IDLE_MODE;
          end else begin
            r_next.st = M_PRIMARY_IDLE_MODE;
          end
        end
      end
      M_SLEEP, M_SECONDARY_IDLE_MODE, M_INT_IDLE, M_PRIMARY_IDLE_MODE: begin
        if (wake) begin
          // Start delay always begins at the wake event
          r_next.st = M_WAKE;
          cpu_start_delay_go = 1'b1;
          r_next.cpu_start_delay_ok = 1'b0;
          r_next.osc_ok = 1'b1;
          r_next.need_pll = 1'b0;
          r_next.wcnt = '0;
          if (reset_wake) begin
            r_next.cause = WK_RST;
          end else if (watchdog_timeout) begin
            r_next.cause = WK_WDT;
          end else begin
            r_next.cause = WK_IRQ;
          end
          if (reset_wake) begin
            // Reset returns to the primary clock; no oscillator start-up timer from primary idle
            r_next.src = SRC_PRI;
            r_next.sec_flag = 1'b0;
            if (r_reg.st != M_PRIMARY_IDLE_MODE && needs_ost(primary_kind)) begin
              ost_go = 1'b1;
              r_next.osc_ok = 1'b0;
              r_next.need_pll = (primary_kind == PK_CRYSTAL_PLL);
            end
          end else if (r_reg.st == M_SLEEP) begin
            // Sleep wakes to the run mode the select bits name
            if (system_clock_select[SEL_HI_BIT]) begin
              r_next.src = SRC_INT;
            end else if (system_clock_select[SEL_LO_BIT]) begin
              r_next.src = SRC_SEC;
              r_next.sec_flag = 1'b1;
            end else begin
              r_next.src = SRC_PRI;
              if (needs_ost(primary_kind)) begin
                ost_go = 1'b1;
                r_next.osc_ok = 1'b0;
                r_next.need_pll = (primary_kind == PK_CRYSTAL_PLL);
              end
            end
          end
          // Idle wakes keep the idle clock source and select bits
        end
      end
      M_WAKE: begin
        r_next.wcnt = r_reg.wcnt + W'(1);
        if (cpu_start_delay_done) begin
          r_next.cpu_start_delay_ok = 1'b1;
        end
        if (ost_done) begin
          // PLL lock follows the start-up timer
          pll_go = r_reg.need_pll;
          r_next.osc_ok = !r_reg.need_pll;
        end
        if (pll_done) begin
          r_next.osc_ok = 1'b1;
        end
        // Internal stabilisation never stalls execution
        if ((r_reg.cpu_start_delay_ok || cpu_start_delay_done) && r_next.osc_ok) begin
          r_next.st = M_RUN;
          r_next.resume = 1'b1;
          if (r_reg.src == SRC_PRI) begin
            r_next.pri_flag = 1'b1;
          end
          r_next.restart = (r_reg.cause == WK_RST);
          r_next.vec_pend = (r_reg.cause == WK_IRQ) && global_interrupt_enable;
        end
      end
      default: begin
        r_next.st = M_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.st <= M_RUN;
      r_reg.src <= SRC_PRI;
      r_reg.cause <= WK_IRQ;
      r_reg.pri_flag <= PRI_FLAG_RESET;
      r_reg.sec_flag <= SEC_FLAG_RESET;
      r_reg.ifs <= FREQ_SEL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Delay counters; start-up delay and oscillator start-up timer run together, PLL lock after
  delay_timer #(.W(W)) u_cpu_start (
    .clk(clk), .nrst(nrst), .start(cpu_start_delay_go), .load(W'(CPU_START)),
    .busy(), .done(cpu_start_delay_done)
  );
  delay_timer #(.W(W)) u_stabilize (
    .clk(clk), .nrst(nrst), .start(stab_go), .load(W'(STABILIZE)),
    .busy(stab_busy), .done(stab_done)
  );
  delay_timer #(.W(W)) u_osc_startup (
    .clk(clk), .nrst(nrst), .start(ost_go), .load(W'(OSC_STARTUP)),
    .busy(), .done(ost_done)
  );
  delay_timer #(.W(W)) u_pll_lock (
    .clk(clk), .nrst(nrst), .start(pll_go), .load(W'(PLL_LOCK)),
    .busy(), .done(pll_done)
  );

  // Gating: the CPU runs only in run mode, peripherals stop only in sleep
  assign cpu_clock_en = (r_reg.st == M_RUN);
  assign periph_clock_en = (r_reg.st != M_SLEEP);
  assign clock_source = r_reg.src;
  assign primary_osc_en = (r_reg.src == SRC_PRI) && (r_reg.st != M_SLEEP);
  assign secondary_osc_en = secondary_oscillator_any | (r_reg.src == SRC_SEC);
  assign high_freq_internal_en = hf_on;
  // Low-frequency source stays up for watchdog or clock monitor
  assign low_freq_internal_en = watchdog_enable | failsafe_enable | ((r_reg.src == SRC_INT) && !hf_req);
  assign primary_clock_running_flag = r_reg.pri_flag;
  assign secondary_clock_running_flag = r_reg.sec_flag;
  assign high_internal_stable_flag = r_reg.stable && !medium_freq_select;
  assign medium_internal_stable_flag = r_reg.stable && medium_freq_select;
  assign internal_freq_select = r_reg.ifs;
  assign resume_exec = r_reg.resume;
  assign vector_request = r_reg.vector;
  assign restart_at_zero = r_reg.restart;
  assign watchdog_clear = r_reg.wdt_clr;
  assign watchdog_reset = r_reg.wdt_rst;
  assign power_mode = r_reg.st;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_sleep_cmd;
    r_reg.st == M_RUN && sleep_exec && !watchdog_timeout;
  endsequence

  sequence s_irq_resume;
    resume_exec && !restart_at_zero;
  endsequence

  a_secondary_idle_mode_entry: assert property (s_sleep_cmd and idle_select && system_clock_select == 2'h1 && secondary_oscillator_any
    |=> !cpu_clock_en && periph_clock_en && secondary_clock_running_flag && !primary_clock_running_flag)
    else $error("secondary idle entry wrong");
  a_fallback_idle: assert property (s_sleep_cmd and idle_select && system_clock_select == 2'h1 && !secondary_oscillator_any
    |=> !secondary_clock_running_flag && power_mode != M_SECONDARY_IDLE_MODE)
    else $error("secondary idle entered without enable");
  a_int_idle_entry: assert property (s_sleep_cmd and idle_select && system_clock_select[1]
    |=> power_mode == M_INT_IDLE && !primary_osc_en && !primary_clock_running_flag)
    else $error("internal idle entry wrong");
  a_sleep_clears: assert property (s_sleep_cmd and !idle_select
    |=> !periph_clock_en && !primary_clock_running_flag && !high_internal_stable_flag && !medium_internal_stable_flag)
    else $error("sleep left a status flag set");
  a_wdt_run_reset: assert property (r_reg.st == M_RUN && watchdog_timeout |=> watchdog_reset && cpu_clock_en)
    else $error("watchdog time-out in run gave no reset");
  a_wdt_clear_sleep: assert property (s_sleep_cmd |=> watchdog_clear)
    else $error("sleep did not clear watchdog");
  a_start_delay: assert property (resume_exec |-> r_reg.wcnt >= W'(CPU_START))
    else $error("execution resumed before start delay");
  a_vector_gie: assert property (s_irq_resume ##0 r_reg.cause == WK_IRQ ##1 1'b1
    |-> vector_request == $past(r_reg.vec_pend))
    else $error("vector request not after next instruction");
  a_reset_zero: assert property (resume_exec && r_reg.cause == WK_RST |-> restart_at_zero)
    else $error("reset wake did not restart at zero");
  a_no_spurious_wake: assert property (r_reg.st inside {M_SLEEP, M_SECONDARY_IDLE_MODE, M_INT_IDLE, M_PRIMARY_IDLE_MODE} && !wake
    |=> power_mode != M_WAKE)
    else $error("wake without a trigger");
  a_hf_off_clear: assert property (!hf_req |=> !high_internal_stable_flag && !medium_internal_stable_flag)
    else $error("stability flag without internal output");

endmodule

// *** test/core_model.sv ***
`timescale 1ns/10ps
module core_model
  import idle_wake_pkg::*;
(
  // Clock
  input wire logic clk,
  // Instruction events
  output logic sleep_exec,
  output logic watchdog_clear_exec,
  // Interrupt flags raised by peripherals
  output logic [IRQ_COUNT-1:0] irq_flag
);
  // Core starts executing with nothing pending
  initial begin
    sleep_exec = 1'b0;
    watchdog_clear_exec = 1'b0;
    irq_flag = '0;
  end

  // One-cycle instruction pulse, launched just after an edge
  task automatic op(input bit clr);
    @(posedge clk);
    #1;
    if (clr) begin
      watchdog_clear_exec = 1'b1;
    end else begin
      sleep_exec = 1'b1;
    end
    @(posedge clk);
    #1;
    sleep_exec = 1'b0;
    watchdog_clear_exec = 1'b0;
  endtask

  // Flags are levels: they stay up until software clears them
  task automatic set_irq(input logic [IRQ_COUNT-1:0] v);
    @(posedge clk);
    #1;
    irq_flag = v;
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import idle_wake_pkg::*;
;
  // Shortened delay counts, so a crystal wake stays short
  localparam int L = 4;
  localparam int S = 6;
  localparam int O = 10;
  localparam int P = 8;
  // Clock, reset and counters
  logic clk;
  logic nrst;
  int n_fail;
  int tests_run;
  // Bench-driven inputs
  logic idle_select, secondary_osc_force_on, low_freq_source_select, medium_freq_select;
  logic freq_write, global_interrupt_enable, watchdog_timeout, reset_wake, clock_lost;
  logic watchdog_enable, failsafe_enable;
  logic [1:0] system_clock_select;
  logic [2:0] tmr_en;
  logic [2:0] freq_wdata;
  logic [7:0] irq_enable;
  prim_t primary_kind;
  // Core-driven inputs
  logic sleep_exec, watchdog_clear_exec;
  logic [7:0] irq_flag;
  // Observed outputs
  logic cpu_clock_en, periph_clock_en, primary_osc_en, secondary_osc_en;
  logic high_freq_internal_en, low_freq_internal_en, primary_clock_running_flag;
  logic secondary_clock_running_flag, high_internal_stable_flag, medium_internal_stable_flag;
  logic resume_exec, vector_request, restart_at_zero, watchdog_clear, watchdog_reset;
  logic [2:0] internal_freq_select;
  src_t clock_source;
  mode_t power_mode;
  // Expected wake windows for each primary kind, in bench cycles
  // Crystal, crystal with PLL, external or RC, internal; the upper bound rules out an added start delay
  int lo_tab [4] = '{O + 2, O + P + 2, L + 2, L + 2};
  int hi_tab [4] = '{O + 5, O + P + 5, L + 2, L + 2};

  core_model core (.clk, .sleep_exec, .watchdog_clear_exec, .irq_flag);

  idle_wake_ctrl #(.CPU_START(L), .STABILIZE(S), .OSC_STARTUP(O), .PLL_LOCK(P)) DUT (
    .clk, .nrst, .sleep_exec, .watchdog_clear_exec, .idle_select, .system_clock_select,
    .secondary_osc_force_on, .timer_a_secondary_osc_enable(tmr_en[0]),
    .timer_b_secondary_osc_enable(tmr_en[1]), .timer_c_secondary_osc_enable(tmr_en[2]),
    .low_freq_source_select, .medium_freq_select, .freq_write, .freq_wdata, .primary_kind,
    .watchdog_enable, .failsafe_enable, .irq_flag, .irq_enable, .global_interrupt_enable,
    .watchdog_timeout, .reset_wake, .clock_lost, .cpu_clock_en, .periph_clock_en, .clock_source,
    .primary_osc_en, .secondary_osc_en, .high_freq_internal_en, .low_freq_internal_en,
    .primary_clock_running_flag, .secondary_clock_running_flag, .high_internal_stable_flag,
    .medium_internal_stable_flag, .internal_freq_select, .resume_exec, .vector_request,
    .restart_at_zero, .watchdog_clear, .watchdog_reset, .power_mode
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One-cycle event pulse: 1 watchdog time-out, 2 reset wake, 3 clock loss
  task automatic pulse(input int sel);
    @(posedge clk);
    #1;
    case (sel)
      1: watchdog_timeout = 1'b1;
      2: reset_wake = 1'b1;
      default: clock_lost = 1'b1;
    endcase
    @(posedge clk);
    #1;
    watchdog_timeout = 1'b0;
    reset_wake = 1'b0;
    clock_lost = 1'b0;
  endtask

  // Wake by kind (0 interrupt), then measure cycles until execution resumes
  task automatic wake(input int k, input int lo, input int hi, input logic rz, input logic vr);
    int n;
    n = 1;
    if (k == 0) begin
      core.set_irq(8'h01);
      @(posedge clk);
      #1;
    end else begin
      pulse(k);
    end
    chk("wake mode", M_WAKE, power_mode);
    while (n < 40 && resume_exec !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    tests_run++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("[FAIL] wake delay expected %0d..%0d seen %0d", lo, hi, n);
    end
    chk("restart at zero", rz, restart_at_zero);
    chk("run mode", M_RUN, power_mode);
    @(posedge clk);
    #1;
    chk("vector", vr, vector_request);
    core.set_irq(8'h00);
  endtask

  // Hang guard: the full sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    {idle_select, secondary_osc_force_on, low_freq_source_select, medium_freq_select} = 4'h0;
    {freq_write, global_interrupt_enable, watchdog_timeout, reset_wake, clock_lost} = 5'h00;
    {watchdog_enable, failsafe_enable} = 2'h0;
    system_clock_select = 2'h0;
    tmr_en = 3'h0;
    freq_wdata = 3'h0;
    irq_enable = 8'h00;
    primary_kind = PK_CRYSTAL;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("mode", M_RUN, power_mode);
    chk("source", SRC_PRI, clock_source);
    chk("pri flag", 1, primary_clock_running_flag);
    chk("freq sel", FREQ_SEL_RESET, internal_freq_select);
    chk("hi stable early", 0, high_internal_stable_flag);
    repeat (S + 3) @(posedge clk);
    #1;
    chk("hi stable", 1, high_internal_stable_flag);
    chk("cpu runs", 1, cpu_clock_en);
    medium_freq_select = 1'b1;
    #1;
    chk("med stable", 1, medium_internal_stable_flag);
    chk("hi off", 0, high_internal_stable_flag);
    medium_freq_select = 1'b0;
    // No secondary enable: fall back to primary idle
    idle_select = 1'b1;
    system_clock_select = 2'h1;
    irq_enable = 8'h01;
    core.op(1'b0);
    chk("fallback", M_PRIMARY_IDLE_MODE, power_mode);
    chk("fb source", SRC_PRI, clock_source);
    chk("cpu off", 0, cpu_clock_en);
    chk("sleep clears", 1, watchdog_clear);
    core.set_irq(8'h80);
    repeat (20) @(posedge clk);
    #1;
    chk("masked irq", M_PRIMARY_IDLE_MODE, power_mode);
    wake(1, L + 2, L + 2, 1'b0, 1'b0);
    // Secondary idle with one timer enable, interrupt wake with vectoring
    tmr_en = 3'h2;
    global_interrupt_enable = 1'b1;
    core.op(1'b0);
    chk("secondary_idle_mode", M_SECONDARY_IDLE_MODE, power_mode);
    chk("periph on", 1, periph_clock_en);
    chk("sec flag", 1, secondary_clock_running_flag);
    chk("pri flag off", 0, primary_clock_running_flag);
    chk("pri osc off", 0, primary_osc_en);
    wake(0, L + 2, L + 2, 1'b0, 1'b1);
    chk("sec kept", SRC_SEC, clock_source);
    chk("sec osc", 1, secondary_osc_en);
    // Internal idle with the lower select bit set
    tmr_en = 3'h0;
    global_interrupt_enable = 1'b0;
    watchdog_enable = 1'b1;
    system_clock_select = 2'h3;
    core.op(1'b0);
    chk("int idle", M_INT_IDLE, power_mode);
    chk("int source", SRC_INT, clock_source);
    chk("int pri flag", 0, primary_clock_running_flag);
    chk("hf on", 1, high_freq_internal_en);
    chk("stable kept", 1, high_internal_stable_flag);
    chk("lf on", 1, low_freq_internal_en);
    @(posedge clk);
    #1;
    freq_write = 1'b1;
    @(posedge clk);
    #1;
    freq_write = 1'b0;
    chk("freq zero", 0, internal_freq_select);
    chk("write clears", 1, watchdog_clear);
    chk("hf off", 0, high_freq_internal_en);
    @(posedge clk);
    #1;
    chk("flags off", 0, {high_internal_stable_flag, medium_internal_stable_flag});
    // Source bit alone turns the internal output back on
    low_freq_source_select = 1'b1;
    #1;
    chk("src bit on", 1, high_freq_internal_en);
    low_freq_source_select = 1'b0;
    wake(0, L + 2, L + 2, 1'b0, 1'b0);
    chk("int kept", SRC_INT, clock_source);
    // Other watchdog clearing events and a time-out while running
    failsafe_enable = 1'b1;
    pulse(3);
    chk("loss clears", 1, watchdog_clear);
    core.op(1'b1);
    chk("watchdog_clear_instruction clears", 1, watchdog_clear);
    pulse(1);
    chk("wdt reset", 1, watchdog_reset);
    // Full sleep and reset wake for each primary kind
    idle_select = 1'b0;
    system_clock_select = 2'h0;
    for (int k = 0; k < 4; k++) begin
      primary_kind = prim_t'(k);
      core.op(1'b0);
      chk("sleep", M_SLEEP, power_mode);
      chk("periph off", 0, periph_clock_en);
      chk("flags clear", 0, {primary_clock_running_flag, secondary_clock_running_flag});
      wake(2, lo_tab[k], hi_tab[k], 1'b1, 1'b0);
    end
    // Each secondary enable alone keeps that oscillator up; the last pass has none
    for (int i = 0; i < 5; i++) begin
      {secondary_osc_force_on, tmr_en} = 4'h1 << i;
      @(posedge clk);
      #1;
      chk("sec osc en", i < 4, secondary_osc_en);
    end
    // Frequency write on the primary clock leaves the watchdog alone
    freq_wdata = 3'h5;
    freq_write = 1'b1;
    @(posedge clk);
    #1;
    freq_write = 1'b0;
    chk("freq five", 8'h05, internal_freq_select);
    chk("no clear", 0, watchdog_clear);
    repeat (S + 3) @(posedge clk);
    #1;
    chk("restable", 1, high_internal_stable_flag);
    // Full sleep must drop a stability flag that was set
    core.op(1'b0);
    chk("sleep stable", 0, {high_internal_stable_flag, medium_internal_stable_flag});
    results();
  end
endmodule
